/* File: logic/flash_array.sv */
// Byte array of the flash model plus lock bits of the program ROM blocks.
// Assumes one write action per cycle, chosen by the sequencer.
`timescale 1ns/10ps
module flash_array
	import flash_seq_pkg::*;
#(
	parameter int N_LOCK = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [ARR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic prog_we,
	input wire logic [ARR_W-1:0] prog_addr,
	input wire logic [7:0] prog_data,
	output logic [7:0] prog_old,
	input wire logic erase_we,
	input wire logic [BLK_W-1:0] erase_blk,
	input wire logic lock_we,
	input wire logic [1:0] lock_idx,
	input wire logic lock_val,
	output logic [N_LOCK-1:0] lock_bits,
	input wire logic [BLK_W-1:0] blank_blk,
	output logic blank
);
	typedef struct packed {
		logic [N_LOCK-1:0] lock;
	} arr_t;

	logic [7:0] mem [0:(1<<ARR_W)-1];
	arr_t s;
	arr_t next_s;

	// Programming can only clear bits, as real cells do
	always_ff @(posedge clk) begin
		if (ce && prog_we) begin
			mem[prog_addr] <= mem[prog_addr] & prog_data;
		end else if (ce && erase_we) begin
			for (int i = 0; i < (1 << OFS_W); i++) begin
				mem[{erase_blk, OFS_W'(i)}] <= BLANK_BYTE;
			end
		end
	end

	always_comb begin
		next_s = s;
		if (lock_we) begin
			next_s.lock[lock_idx] = lock_val;
		end
	end

	// Lock bits are nonvolatile in silicon; here reset leaves every block unlocked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	always_comb begin
		blank = 1'b1;
		for (int i = 0; i < (1 << OFS_W); i++) begin
			if (mem[{blank_blk, OFS_W'(i)}] != BLANK_BYTE) begin
				blank = 1'b0;
			end
		end
	end

	assign rd_data = mem[rd_addr];
	assign prog_old = mem[prog_addr];
	assign lock_bits = s.lock;
endmodule

/* File: logic/flash_command_sequencer.sv */
// Command decoder and sequencer for the on-chip flash in CPU rewrite mode.
// Assumes a byte port on the same clock: one-cycle strobes, read data one cycle later.
// How it works
// - Commands, addresses and data move as bytes.
// - FFh first cycle selects read array mode.
// - Read array after reset, ops, suspend.
// - 50h clears both error flags.
// - 40h then data programs one byte.
// - Ready low while programming, result in flag.
// - Inhibit bits reject data flash rewrites.
// - Lock bit refuses program ROM rewrites.
// - Interrupt when program or erase ends.
// - 20h then D0h erases a block.
// - Ready low erasing; block reads FFh.
// - Interrupt when erase actually suspends.
// - 77h then D0h locks a block.
// - Ready low while lock bit writes.
// - 71h then D0h copies lock bit out.
// - 25h then D0h runs blank check.
// - Blank check result in erase flag.
// - Bad confirm flags error; FFh cancels.
// - Flag pair encodes the error kind.
`timescale 1ns/10ps
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter logic [CNT_W-1:0] PROG_LEN = PROG_CYCLES,
	parameter logic [CNT_W-1:0] ERASE_LEN = ERASE_CYCLES,
	parameter logic [CNT_W-1:0] BLANK_LEN = BLANK_CYCLES,
	parameter logic [CNT_W-1:0] LOCK_LEN = LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire flash_seq_pkg::bus_req_t req,
	output logic [7:0] rdata,
	output flash_seq_pkg::status_t status,
	output flash_seq_pkg::ctrl_t ctrl,
	output logic flash_ready_irq
);
	import flash_seq_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		state_t st;
		logic arr_mode;
		logic pend;
		logic [7:0] pcode;
		logic [BLK_W-1:0] eblk;
		logic [ARR_W-1:0] oaddr;
		logic [7:0] odata;
		logic reject;
		status_t stat;
		ctrl_t ctrl;
		logic irq;
		logic [7:0] rdata;
	} regs_t;

	regs_t s;
	regs_t next_s;

	logic [7:0] mem_rd;
	logic [7:0] prog_old;
	logic [3:0] lock_bits;
	logic blank;
	logic op_done;
	logic erase_done;
	logic t_load;
	logic [CNT_W-1:0] t_val;
	logic e_load;
	logic prog_we;
	logic erase_we;
	logic lock_we;
	logic lock_val;
	logic accept;
	logic start_any;
	logic short_busy;
	logic [BLK_W-1:0] req_blk;
	logic [BLK_W-1:0] oblk;
	logic [3:0] inhibit;
	logic req_refused;
	logic seq_err;

	assign req_blk = req.addr[ARR_W-1:OFS_W];
	assign oblk = s.oaddr[ARR_W-1:OFS_W];
	assign inhibit = {s.ctrl.dflash_d_inhibit, s.ctrl.dflash_c_inhibit,
		s.ctrl.dflash_b_inhibit, s.ctrl.dflash_a_inhibit};
	assign short_busy = (s.st == ST_PROG) || (s.st == ST_BLANK) || (s.st == ST_LOCKW) || (s.st == ST_LOCKR);

	// Commands are taken only while ready; command writes during a busy period are dropped, control register writes still land
	assign accept = req.wr && !req.addr[ADDR_W-1]
		&& ((s.st == ST_IDLE) || ((s.st == ST_SUSP) && s.ctrl.suspend_request));

	// Lower half holds data flash blocks A to D, which carry no lock bit
	always_comb begin
		req_refused = 1'b0;
		if (!req_blk[BLK_W-1]) begin
			req_refused = inhibit[req_blk[1:0]];
		end else if (!s.ctrl.lock_disable) begin
			req_refused = !lock_bits[req_blk[1:0]];
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.irq = 1'b0;
		t_load = 1'b0;
		t_val = PROG_LEN;
		e_load = 1'b0;
		prog_we = 1'b0;
		erase_we = 1'b0;
		lock_we = 1'b0;
		lock_val = 1'b0;
		start_any = 1'b0;
		seq_err = 1'b0;

		if (req.rd) begin
			if (req.addr == CTRL_OFS) begin
				next_s.rdata = s.ctrl;
			end else if (req.addr == STAT_OFS) begin
				next_s.rdata = s.stat;
			end else if (req.addr[ADDR_W-1]) begin
				next_s.rdata = 8'h00;
			end else begin
				next_s.rdata = s.arr_mode ? mem_rd : s.stat;
			end
		end
		if (accept) begin
			if (s.pend) begin
				next_s.pend = 1'b0;
				if (s.stat.erase_suspend_flag && req_blk == s.eblk) begin
					seq_err = 1'b1;
				end else if (s.pcode == CMD_PROGRAM) begin
					start_any = 1'b1;
					next_s.st = ST_PROG;
					next_s.odata = req.wdata;
					next_s.reject = req_refused;
					t_load = 1'b1;
					t_val = req_refused ? REJECT_CYCLES : PROG_LEN;
				end else if (req.wdata == CMD_CONFIRM) begin
					unique case (s.pcode)
						CMD_ERASE: begin
							if (s.stat.erase_suspend_flag) begin
								seq_err = 1'b1;
							end else begin
								start_any = 1'b1;
								next_s.st = ST_ERASE;
								next_s.eblk = req_blk;
								next_s.reject = req_refused;
								e_load = 1'b1;
								t_val = req_refused ? REJECT_CYCLES : ERASE_LEN;
							end
						end
						CMD_BLANK: begin
							if (s.stat.erase_suspend_flag) begin
								seq_err = 1'b1;
							end else begin
								start_any = 1'b1;
								next_s.st = ST_BLANK;
								t_load = 1'b1;
								t_val = BLANK_LEN;
							end
						end
						CMD_LOCK_PROG: begin
							start_any = 1'b1;
							next_s.st = ST_LOCKW;
							t_load = 1'b1;
							t_val = LOCK_LEN;
						end
						default: begin
							start_any = 1'b1;
							next_s.st = ST_LOCKR;
							t_load = 1'b1;
							t_val = LOCK_LEN;
						end
					endcase
				end else if (req.wdata == CMD_READ_ARRAY) begin
					next_s.arr_mode = 1'b1;
				end else begin
					seq_err = 1'b1;
				end
				if (start_any) begin
					next_s.oaddr = req.addr[ARR_W-1:0];
					next_s.stat.ready_flag = 1'b0;
					next_s.arr_mode = 1'b0;
				end
			end else begin
				unique case (req.wdata)
					CMD_READ_ARRAY: next_s.arr_mode = 1'b1;
					CMD_CLEAR: begin
						next_s.stat.erase_error_flag = 1'b0;
						next_s.stat.program_error_flag = 1'b0;
						next_s.arr_mode = 1'b1;
					end
					CMD_PROGRAM, CMD_ERASE, CMD_BLANK, CMD_LOCK_PROG, CMD_LOCK_READ: begin
						next_s.pend = 1'b1;
						next_s.pcode = req.wdata;
						next_s.arr_mode = 1'b0;
					end
					default: seq_err = 1'b1;
				endcase
			end
		end

		if (seq_err) begin
			next_s.stat.erase_error_flag = 1'b1;
			next_s.stat.program_error_flag = 1'b1;
			next_s.ctrl.lock_disable = 1'b0;
		end

		// Completion of the short operations
		if (short_busy && op_done) begin
			next_s.st = s.stat.erase_suspend_flag ? ST_SUSP : ST_IDLE;
			next_s.stat.ready_flag = 1'b1;
			next_s.arr_mode = 1'b1;
			next_s.ctrl.lock_disable = 1'b0;
			unique case (s.st)
				ST_PROG: begin
					prog_we = !s.reject;
					if (s.reject || ((prog_old & s.odata) != s.odata)) begin
						next_s.stat.program_error_flag = 1'b1;
					end
					next_s.irq = s.ctrl.ready_irq_enable;
				end
				ST_BLANK: begin
					if (!blank) begin
						next_s.stat.erase_error_flag = 1'b1;
					end
				end
				ST_LOCKW: begin
					lock_we = oblk[BLK_W-1];
					lock_val = 1'b0;
				end
				default: begin
					next_s.stat.lock_bit_readback = oblk[BLK_W-1] ? lock_bits[oblk[1:0]] : 1'b1;
				end
			endcase
		end

		if (s.st == ST_ERASE) begin
			if (erase_done) begin
				next_s.st = ST_IDLE;
				next_s.stat.ready_flag = 1'b1;
				next_s.arr_mode = 1'b1;
				next_s.ctrl.lock_disable = 1'b0;
				erase_we = !s.reject;
				lock_we = !s.reject && s.eblk[BLK_W-1];
				lock_val = 1'b1;
				if (s.reject) begin
					next_s.stat.erase_error_flag = 1'b1;
				end
				next_s.irq = s.ctrl.ready_irq_enable;
			end else if (s.ctrl.suspend_enable && s.ctrl.suspend_request) begin
				next_s.st = ST_SUSP;
				next_s.stat.ready_flag = 1'b1;
				next_s.stat.erase_suspend_flag = 1'b1;
				next_s.arr_mode = 1'b1;
				next_s.irq = s.ctrl.ready_irq_enable;
			end
		end else if (s.st == ST_SUSP && !s.ctrl.suspend_request) begin
			next_s.st = ST_ERASE;
			next_s.pend = 1'b0;
			next_s.stat.ready_flag = 1'b0;
			next_s.stat.erase_suspend_flag = 1'b0;
			next_s.arr_mode = 1'b0;
		end

		// Software write last, so a same-cycle write of lock_disable beats its hardware clear
		if (req.wr && req.addr == CTRL_OFS) begin
			next_s.ctrl = req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.arr_mode <= 1'b1;
			s.stat.ready_flag <= 1'b1;
			s.ctrl <= CTRL_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign status = s.stat;
	assign ctrl = s.ctrl;
	assign flash_ready_irq = s.irq;

	// ----------------------------------------
	// Timers and array
	// ----------------------------------------
	// The erase timer is separate so a suspended erase keeps its progress across nested ops
	op_timer #(.W(CNT_W)) u_op_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.load(t_load),
		.load_val(t_val),
		.run(short_busy),
		.done(op_done)
	);

	op_timer #(.W(CNT_W)) u_erase_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.load(e_load),
		.load_val(t_val),
		.run(s.st == ST_ERASE),
		.done(erase_done)
	);

	flash_array #(.N_LOCK(4)) u_array (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.rd_addr(req.addr[ARR_W-1:0]),
		.rd_data(mem_rd),
		.prog_we(prog_we),
		.prog_addr(s.oaddr),
		.prog_data(s.odata),
		.prog_old(prog_old),
		.erase_we(erase_we),
		.erase_blk(s.eblk),
		.lock_we(lock_we),
		.lock_idx(oblk[1:0]),
		.lock_val(lock_val),
		.lock_bits(lock_bits),
		.blank_blk(oblk),
		.blank(blank)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_ready_drop;
		ce && start_any |=> !status.ready_flag;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready did not drop after command");

	property p_read_array;
		ce && accept && !s.pend && req.wdata == CMD_READ_ARRAY |=> s.arr_mode;
	endproperty
	a_read_array: assert property (p_read_array) else $error("read array mode not entered");

	property p_clear;
		ce && accept && !s.pend && req.wdata == CMD_CLEAR
			|=> !status.erase_error_flag && !status.program_error_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("clear status left an error flag");

	property p_prog_end;
		ce && s.st == ST_PROG && op_done |=> status.ready_flag && s.arr_mode;
	endproperty
	a_prog_end: assert property (p_prog_end) else $error("program end not ready");

	property p_reject;
		ce && s.st == ST_PROG && s.reject && op_done |=> status.program_error_flag;
	endproperty
	a_reject: assert property (p_reject) else $error("rejected program without error");

	property p_irq;
		ce && s.st == ST_ERASE && erase_done && s.ctrl.ready_irq_enable |=> flash_ready_irq ##1 !flash_ready_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("erase end interrupt wrong");

	property p_suspend;
		ce && s.st == ST_ERASE && !erase_done && s.ctrl.suspend_enable && s.ctrl.suspend_request
			|=> status.erase_suspend_flag && status.ready_flag && s.st == ST_SUSP;
	endproperty
	a_suspend: assert property (p_suspend) else $error("erase did not suspend");

	property p_seq_err;
		ce && accept && s.pend && s.pcode != CMD_PROGRAM && req.wdata != CMD_CONFIRM
			&& req.wdata != CMD_READ_ARRAY |=> status.erase_error_flag && status.program_error_flag;
	endproperty
	a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged");

	property p_busy;
		s.st != ST_IDLE && s.st != ST_SUSP |-> !status.ready_flag;
	endproperty
	a_busy: assert property (p_busy) else $error("ready high while busy");

	c_prog: cover property (ce && s.st == ST_PROG && op_done && !s.reject);
	c_erase: cover property (ce && s.st == ST_ERASE && erase_done);
	c_susp: cover property (ce && s.st == ST_SUSP ##1 s.st == ST_ERASE);
	c_blank_fail: cover property (ce && s.st == ST_BLANK && op_done && !blank);
endmodule

/* File: logic/flash_seq_pkg.sv */
// Shared constants and carriers for the flash command sequencer.
// Assumes one 20 MHz clock and a byte-wide CPU access port.
package flash_seq_pkg;

	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam int ADDR_W = 10;
	localparam int ARR_W = 9;
	localparam int OFS_W = 6;
	localparam int BLK_W = 3;
	localparam int CNT_W = 16;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 10'h200;
	localparam logic [ADDR_W-1:0] STAT_OFS = 10'h201;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
	localparam logic [7:0] CMD_LOCK_READ = 8'h71;
	localparam logic [7:0] CMD_BLANK = 8'h25;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;

	// ----------------------------------------
	// Reset values and operation lengths
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [CNT_W-1:0] PROG_CYCLES = 16'h0028;
	localparam logic [CNT_W-1:0] ERASE_CYCLES = 16'h1F40;
	localparam logic [CNT_W-1:0] BLANK_CYCLES = 16'h0080;
	localparam logic [CNT_W-1:0] LOCK_CYCLES = 16'h0028;
	localparam logic [CNT_W-1:0] REJECT_CYCLES = 16'h0002;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic dflash_d_inhibit;
		logic dflash_c_inhibit;
		logic dflash_b_inhibit;
		logic dflash_a_inhibit;
		logic lock_disable;
		logic suspend_request;
		logic suspend_enable;
		logic ready_irq_enable;
	} ctrl_t;

	typedef struct packed {
		logic ready_flag;
		logic erase_suspend_flag;
		logic erase_error_flag;
		logic program_error_flag;
		logic lock_bit_readback;
		logic [2:0] pad;
	} status_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PROG = 3'b001,
		ST_ERASE = 3'b010,
		ST_BLANK = 3'b011,
		ST_LOCKW = 3'b100,
		ST_LOCKR = 3'b101,
		ST_SUSP = 3'b110
	} state_t;

endpackage

/* File: logic/op_timer.sv */
// Down counter that times one automatic operation.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/10ps
module op_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic run,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} tmr_t;

	tmr_t s;
	tmr_t next_s;

	always_comb begin
		next_s = s;
		if (load) begin
			next_s.cnt = load_val;
		end else if (run && s.cnt != '0) begin
			next_s.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Frozen count holds its place while run is low, which is what lets erase resume
	assign done = (s.cnt == '0);
endmodule

/* File: testbench/cpu_host_model.sv */
// CPU side of the flash sequencer: byte writes and reads on the plain port.
// Assumes the sequencer samples on the rising edge and never stalls the master.
`timescale 1ns/10ps
module cpu_host_model
	import flash_seq_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output flash_seq_pkg::bus_req_t req
);
	import flash_seq_pkg::*;

	initial begin
		req = '0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Idle cycles carry inverted address and data so stale values never look valid
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 8'hA5};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, 8'h5A};
		#1;
		d = rdata;
	endtask

	// Defined codes except the bad 12h confirm, never a rewrite of a programmed byte, no blank check while suspended
	task automatic cmd2(input logic [7:0] code, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		wr(a, code);
		wr(a, d);
	endtask
endmodule

/* File: testbench/flash_command_sequencer_bench.sv */
// Self-checking bench of the flash command sequencer.
// Assumes short operation lengths set through the parameters below.
`timescale 1ns/10ps
module flash_command_sequencer_bench;
	import flash_seq_pkg::*;

	logic clk;
	logic rst_n;
	logic ce;
	bus_req_t req;
	logic [7:0] rdata;
	status_t status;
	ctrl_t ctrl;
	logic flash_ready_irq;
	int errors;
	int num_checks;
	int irq_cnt;
	int n;
	int i0;
	logic [7:0] d;

	flash_command_sequencer #(.PROG_LEN(16'h0004), .ERASE_LEN(16'h0010), .BLANK_LEN(16'h0008),
		.LOCK_LEN(16'h0004)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata),
		.status(status), .ctrl(ctrl), .flash_ready_irq(flash_ready_irq));
	cpu_host_model u_host (.clk(clk), .rdata(rdata), .req(req));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Counted mid-cycle so a pulse launched at the ready edge is seen before the checks
	always @(negedge clk) begin
		if (flash_ready_irq === 1'b1) irq_cnt <= irq_cnt + 1;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts busy cycles; bounded so a stuck flag cannot hang the run
	task automatic wait_ready(output int cyc);
		cyc = 0;
		#1;
		while (status.ready_flag !== 1'b1 && cyc < 100) begin
			@(posedge clk);
			#1;
			cyc++;
		end
		#30;
	endtask

	task automatic clear_flags();
		u_host.wr(10'h000, CMD_CLEAR);
		#1;
		check(status, 8'h80);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_regs();
		#1;
		check(status, 8'h80);
		check(ctrl, CTRL_RST);
		u_host.wr(CTRL_OFS, 8'h01);
		u_host.rd(CTRL_OFS, d);
		check(d, 8'h01);
		u_host.wr(STAT_OFS, 8'h00);
		u_host.rd(STAT_OFS, d);
		check(d, 8'h80);
		u_host.rd(10'h3F0, d);
		check(d, 8'h00);
		$display("test_regs done");
	endtask

	task automatic test_erase_program();
		i0 = irq_cnt;
		u_host.cmd2(CMD_ERASE, 10'h040, CMD_CONFIRM);
		#1;
		check(status, 8'h00);
		wait_ready(n);
		check(8'(n), 8'd17);
		check(status, 8'h80);
		check(8'(irq_cnt - i0), 8'd1);
		u_host.rd(10'h07F, d);
		check(d, BLANK_BYTE);
		u_host.cmd2(CMD_PROGRAM, 10'h045, 8'hA5);
		#1;
		check(status, 8'h00);
		wait_ready(n);
		check(8'(n), 8'd5);
		check(status, 8'h80);
		check(8'(irq_cnt - i0), 8'd2);
		u_host.rd(10'h045, d);
		check(d, 8'hA5);
		u_host.rd(10'h046, d);
		check(d, BLANK_BYTE);
		u_host.cmd2(CMD_BLANK, 10'h040, CMD_CONFIRM);
		wait_ready(n);
		check(8'(n), 8'd9);
		check(status, 8'hA0);
		clear_flags();
		$display("test_erase_program done");
	endtask

	task automatic test_inhibit();
		u_host.wr(CTRL_OFS, 8'h21);
		u_host.cmd2(CMD_PROGRAM, 10'h050, 8'h00);
		wait_ready(n);
		check(8'(n), 8'd3);
		check(status, 8'h90);
		u_host.wr(10'h050, CMD_READ_ARRAY);
		u_host.rd(10'h050, d);
		check(d, BLANK_BYTE);
		clear_flags();
		u_host.cmd2(CMD_ERASE, 10'h040, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'hA0);
		clear_flags();
		u_host.wr(CTRL_OFS, 8'h01);
		$display("test_inhibit done");
	endtask

	task automatic test_lock();
		u_host.cmd2(CMD_LOCK_PROG, 10'h100, CMD_CONFIRM);
		#1;
		check(status, 8'h00);
		wait_ready(n);
		check(8'(n), 8'd5);
		u_host.wr(10'h13F, CMD_LOCK_READ);
		u_host.wr(10'h100, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'h80);
		u_host.cmd2(CMD_ERASE, 10'h100, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'hA0);
		clear_flags();
		u_host.cmd2(CMD_PROGRAM, 10'h101, 8'h00);
		wait_ready(n);
		check(status, 8'h90);
		clear_flags();
		u_host.wr(CTRL_OFS, 8'h09);
		u_host.cmd2(CMD_ERASE, 10'h100, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'h80);
		check(ctrl, 8'h01);
		u_host.cmd2(CMD_LOCK_READ, 10'h100, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'h88);
		u_host.cmd2(CMD_LOCK_PROG, 10'h100, CMD_CONFIRM);
		wait_ready(n);
		u_host.cmd2(CMD_LOCK_READ, 10'h100, CMD_CONFIRM);
		wait_ready(n);
		check(status, 8'h80);
		$display("test_lock done");
	endtask

	task automatic test_sequence();
		u_host.cmd2(CMD_ERASE, 10'h040, 8'h12);
		#1;
		check(status, 8'hB0);
		clear_flags();
		u_host.cmd2(CMD_ERASE, 10'h040, CMD_READ_ARRAY);
		#1;
		check(status, 8'h80);
		u_host.rd(10'h045, d);
		check(d, 8'hA5);
		$display("test_sequence done");
	endtask

	task automatic test_suspend();
		u_host.wr(CTRL_OFS, 8'h03);
		u_host.cmd2(CMD_ERASE, 10'h080, CMD_CONFIRM);
		repeat (3) @(posedge clk);
		i0 = irq_cnt;
		u_host.wr(CTRL_OFS, 8'h07);
		wait_ready(n);
		check(status, 8'hC0);
		check(8'(irq_cnt - i0), 8'd1);
		u_host.rd(10'h045, d);
		check(d, 8'hA5);
		u_host.wr(CTRL_OFS, 8'h03);
		repeat (2) @(posedge clk);
		#1;
		check(status, 8'h00);
		wait_ready(n);
		check(status, 8'h80);
		check(8'(irq_cnt - i0), 8'd2);
		u_host.cmd2(CMD_BLANK, 10'h0BF, CMD_CONFIRM);
		// A frozen clock enable must stretch the check by exactly the frozen edges
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		wait_ready(n);
		check(8'(n), 8'd9);
		check(status, 8'h80);
		$display("test_suspend done");
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic summarize();
		$display("Checks made %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		errors = 0;
		num_checks = 0;
		irq_cnt = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		test_regs();
		test_erase_program();
		test_inhibit();
		test_lock();
		test_sequence();
		test_suspend();
		summarize();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(50 * 4000);
		errors++;
		summarize();
	end
endmodule
